// File: oscb_regs.svh
// Behaviour
// - four driver power bits, 1 is up
// - mixer amp power in bits one, zero
// - power bits seven, six read zero
// - one bit picks 0.9V or 0.75V
// - two-bit headphone common mode select
// - line common mode bit, regulator supply
// - headphone supply: analog or regulator input
// - regulator range bit, only with supply bit
// - overcurrent detect enable, resets to one
// - three-bit debounce code, 0 for none, else 8ms to 512ms
// - action bit: limit current or power down
// - four routing bits to left headphone
`ifndef OSCB_REGS_SVH
`define OSCB_REGS_SVH

// register indices; byte address is four times the index
`define OSCB_IDX_PAGE 8'h00
`define OSCB_IDX_PWR 8'h09
`define OSCB_IDX_CM 8'h0A
`define OSCB_IDX_OCP 8'h0B
`define OSCB_IDX_ROUTE 8'h0C
`define OSCB_IDX_STAT 8'h3F
`define OSCB_PAGE_OWN 8'h01

// writable bits of each register
`define OSCB_MASK_PWR 8'h3F
`define OSCB_MASK_CM 8'h7B
`define OSCB_MASK_OCP 8'h1F
`define OSCB_MASK_ROUTE 8'h0F
`define OSCB_MASK_STAT 8'h03

`define OSCB_RST_PAGE 8'h00
`define OSCB_RST_PWR 8'h00
`define OSCB_RST_CM 8'h00
`define OSCB_RST_OCP 8'h10
`define OSCB_RST_ROUTE 8'h00

`define OSCB_PWR_LHP 5
`define OSCB_PWR_RHP 4
`define OSCB_PWR_LLINE 3
`define OSCB_PWR_RLINE 2
`define OSCB_PWR_LMIX 1
`define OSCB_PWR_RMIX 0
`define OSCB_CM_CHIP 6
`define OSCB_CM_HP_HI 5
`define OSCB_CM_HP_LO 4
`define OSCB_CM_LINE 3
`define OSCB_CM_HPSUP 1
`define OSCB_CM_RANGE 0
`define OSCB_OCP_EN 4
`define OSCB_OCP_DB_HI 3
`define OSCB_OCP_DB_LO 1
`define OSCB_OCP_ACT 0

`define OSCB_RESP_OKAY 2'h0
`define OSCB_RESP_SLVERR 2'h2

`define OSCB_CLK_MHZ 100
`define OSCB_OCP_BASE_MS 8
`define OSCB_OCP_BASE_CYCLES (`OSCB_OCP_BASE_MS * 1000 * `OSCB_CLK_MHZ)

`endif

// File: oscb_pkg.sv
package oscb_pkg;
   typedef enum logic [1:0] {
      OSCB_OC_IDLE = 2'b00,
      OSCB_OC_COUNT = 2'b01,
      OSCB_OC_HIT = 2'b10
   } oscb_oc_state_t;
endpackage

// File: oscb_ocp_if.sv
interface oscb_ocp_if;
   logic raw;
   logic enable;
   logic [2:0] code;
   logic confirmed;
   modport det (input raw, input enable, input code, output confirmed);
   modport ctl (output raw, output enable, output code, input confirmed);
endinterface

// File: oscb_ocp_debounce.sv
`include "oscb_regs.svh"

module oscb_ocp_debounce #(
   parameter int CNT_W = 32,
   parameter logic [31:0] BASE_CYCLES = 32'(`OSCB_OCP_BASE_CYCLES)
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // detector
   oscb_ocp_if.det oc
);
   oscb_pkg::oscb_oc_state_t state;
   oscb_pkg::oscb_oc_state_t next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   wire logic [CNT_W-1:0] limit = CNT_W'(BASE_CYCLES) << (oc.code - 3'h1);
   wire logic armed = oc.raw && oc.enable;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         oscb_pkg::OSCB_OC_IDLE: begin
            if (armed && oc.code == 3'h0) begin
               next_state = oscb_pkg::OSCB_OC_HIT;
            end else if (armed) begin
               next_state = oscb_pkg::OSCB_OC_COUNT;
               next_cnt = CNT_W'(1);
            end
         end
         oscb_pkg::OSCB_OC_COUNT: begin
            if (!armed) begin
               next_state = oscb_pkg::OSCB_OC_IDLE;
            end else if (cnt >= limit - CNT_W'(1)) begin
               next_state = oscb_pkg::OSCB_OC_HIT;
            end else begin
               next_cnt = cnt + CNT_W'(1);
            end
         end
         oscb_pkg::OSCB_OC_HIT: begin
            if (!armed) begin
               next_state = oscb_pkg::OSCB_OC_IDLE;
            end
         end
         default: next_state = oscb_pkg::OSCB_OC_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= oscb_pkg::OSCB_OC_IDLE;
         cnt <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   assign oc.confirmed = (state == oscb_pkg::OSCB_OC_HIT);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_counting;
      state == oscb_pkg::OSCB_OC_COUNT;
   endsequence
   sequence s_dropped;
      !oc.raw;
   endsequence

   property p_restart;
      s_counting ##0 s_dropped |=> state == oscb_pkg::OSCB_OC_IDLE && !oc.confirmed;
   endproperty
   a_restart: assert property (p_restart) else $error("debounce did not restart on drop");

   property p_no_debounce;
      state == oscb_pkg::OSCB_OC_IDLE && armed && oc.code == 3'h0 |=> oc.confirmed;
   endproperty
   a_no_debounce: assert property (p_no_debounce) else $error("zero code was debounced");

   property p_full_period;
      $rose(oc.confirmed) && $past(oc.code) != 3'h0 |-> $past(cnt) >= $past(limit) - CNT_W'(1);
   endproperty
   a_full_period: assert property (p_full_period) else $error("confirmed before period");
endmodule // oscb_ocp_debounce

// File: oscb_output_stage_bank.sv
`include "oscb_regs.svh"

module oscb_output_stage_bank #(
   parameter logic [31:0] OCP_BASE_CYCLES = 32'(`OSCB_OCP_BASE_CYCLES),
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // raw overcurrent from the headphone drivers
   input wire logic left_headphone_overcurrent,
   input wire logic right_headphone_overcurrent,
   // power controls
   output logic left_headphone_driver_pwr,
   output logic right_headphone_driver_pwr,
   output logic left_line_driver_pwr,
   output logic right_line_driver_pwr,
   output logic left_mixer_amp_pwr,
   output logic right_mixer_amp_pwr,
   // common mode and supply
   output logic chip_cm_low,
   output logic [1:0] headphone_cm_sel,
   output logic line_cm_regulator_input_supply,
   output logic headphone_regulator_input_supply,
   output logic regulator_input_supply_high_range,
   // overcurrent action
   output logic left_headphone_current_limit,
   output logic right_headphone_current_limit,
   // left headphone routing
   output logic [3:0] left_headphone_driver_route
);
   logic [7:0] page;
   logic [7:0] pwr;
   logic [7:0] cm;
   logic [7:0] ocp;
   logic [7:0] route;
   logic [1:0] trip;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_idx;
   logic [7:0] w_byte;
   logic w_lane0;

   oscb_ocp_if oc_left();
   oscb_ocp_if oc_right();

   function automatic logic oscb_mapped(input logic [7:0] idx, input logic [7:0] pg);
      oscb_mapped = (idx == `OSCB_IDX_PAGE) || ((pg == `OSCB_PAGE_OWN) &&
         (idx == `OSCB_IDX_PWR || idx == `OSCB_IDX_CM || idx == `OSCB_IDX_OCP ||
          idx == `OSCB_IDX_ROUTE || idx == `OSCB_IDX_STAT));
   endfunction

   // ---- write channel ----
   wire logic do_write = aw_held && w_held && !bvalid;
   wire logic wr_ok = oscb_mapped(aw_idx, page);
   wire logic wr_en = do_write && wr_ok && w_lane0;
   wire logic wr_page = wr_en && aw_idx == `OSCB_IDX_PAGE;
   wire logic wr_pwr = wr_en && aw_idx == `OSCB_IDX_PWR;
   wire logic wr_cm = wr_en && aw_idx == `OSCB_IDX_CM;
   wire logic wr_ocp = wr_en && aw_idx == `OSCB_IDX_OCP;
   wire logic wr_route = wr_en && aw_idx == `OSCB_IDX_ROUTE;
   wire logic wr_stat = wr_en && aw_idx == `OSCB_IDX_STAT;

   assign awready = !aw_held && !bvalid;
   assign wready = !w_held && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_idx <= 8'h00;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `OSCB_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_idx <= awaddr[9:2];
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_byte <= wdata[7:0];
            w_lane0 <= wstrb[0];
         end else if (do_write) begin
            w_held <= 1'b0;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            bresp <= wr_ok ? `OSCB_RESP_OKAY : `OSCB_RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ---- registers; reserved bits never store, so they read zero ----
   wire logic [1:0] trip_set = {oc_left.confirmed, oc_right.confirmed} & {2{ocp[`OSCB_OCP_ACT]}};
   wire logic [1:0] trip_clr = wr_stat ? w_byte[1:0] : 2'b00;
   // a trip arriving with its clear still latches
   wire logic [1:0] next_trip = trip_set | (trip & ~trip_clr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         page <= `OSCB_RST_PAGE;
         pwr <= `OSCB_RST_PWR;
         cm <= `OSCB_RST_CM;
         ocp <= `OSCB_RST_OCP;
         route <= `OSCB_RST_ROUTE;
         trip <= 2'b00;
      end else begin
         if (wr_page) begin
            page <= w_byte;
         end
         if (wr_pwr) begin
            pwr <= w_byte & `OSCB_MASK_PWR;
         end
         if (wr_cm) begin
            cm <= w_byte & `OSCB_MASK_CM;
         end
         if (wr_ocp) begin
            ocp <= w_byte & `OSCB_MASK_OCP;
         end
         if (wr_route) begin
            route <= w_byte & `OSCB_MASK_ROUTE;
         end
         trip <= next_trip;
      end
   end

   // ---- read channel ----
   wire logic [7:0] ar_idx = araddr[9:2];
   wire logic rd_ok = oscb_mapped(ar_idx, page);
   wire logic [7:0] stat_val = {4'h0, oc_left.confirmed, oc_right.confirmed, trip};
   wire logic [7:0] rd_val =
      (ar_idx == `OSCB_IDX_PAGE) ? page :
      !rd_ok ? 8'h00 :
      (ar_idx == `OSCB_IDX_PWR) ? pwr :
      (ar_idx == `OSCB_IDX_CM) ? cm :
      (ar_idx == `OSCB_IDX_OCP) ? ocp :
      (ar_idx == `OSCB_IDX_ROUTE) ? route : stat_val;

   assign arready = !rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `OSCB_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= {24'h00_0000, rd_val};
         rresp <= rd_ok ? `OSCB_RESP_OKAY : `OSCB_RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ---- overcurrent detection, one debouncer per headphone driver ----
   assign oc_left.raw = left_headphone_overcurrent;
   assign oc_left.enable = ocp[`OSCB_OCP_EN];
   assign oc_left.code = ocp[`OSCB_OCP_DB_HI:`OSCB_OCP_DB_LO];
   assign oc_right.raw = right_headphone_overcurrent;
   assign oc_right.enable = ocp[`OSCB_OCP_EN];
   assign oc_right.code = ocp[`OSCB_OCP_DB_HI:`OSCB_OCP_DB_LO];

   oscb_ocp_debounce #(.BASE_CYCLES(OCP_BASE_CYCLES)) u_deb_left (
      .aclk(aclk),
      .aresetn(aresetn),
      .oc(oc_left.det)
   );
   oscb_ocp_debounce #(.BASE_CYCLES(OCP_BASE_CYCLES)) u_deb_right (
      .aclk(aclk),
      .aresetn(aresetn),
      .oc(oc_right.det)
   );

   // ---- outputs; a tripped driver stays down until software clears it ----
   wire logic next_lhp = pwr[`OSCB_PWR_LHP] && !trip[1];
   wire logic next_rhp = pwr[`OSCB_PWR_RHP] && !trip[0];
   wire logic [1:0] next_limit =
      {oc_left.confirmed, oc_right.confirmed} & {2{!ocp[`OSCB_OCP_ACT]}};
   // range only matters while the headphones run from the regulator input
   wire logic next_range = cm[`OSCB_CM_RANGE] && cm[`OSCB_CM_HPSUP];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         left_headphone_driver_pwr <= 1'b0;
         right_headphone_driver_pwr <= 1'b0;
         left_line_driver_pwr <= 1'b0;
         right_line_driver_pwr <= 1'b0;
         left_mixer_amp_pwr <= 1'b0;
         right_mixer_amp_pwr <= 1'b0;
         chip_cm_low <= 1'b0;
         headphone_cm_sel <= 2'b00;
         line_cm_regulator_input_supply <= 1'b0;
         headphone_regulator_input_supply <= 1'b0;
         regulator_input_supply_high_range <= 1'b0;
         left_headphone_current_limit <= 1'b0;
         right_headphone_current_limit <= 1'b0;
         left_headphone_driver_route <= 4'h0;
      end else begin
         left_headphone_driver_pwr <= next_lhp;
         right_headphone_driver_pwr <= next_rhp;
         left_line_driver_pwr <= pwr[`OSCB_PWR_LLINE];
         right_line_driver_pwr <= pwr[`OSCB_PWR_RLINE];
         left_mixer_amp_pwr <= pwr[`OSCB_PWR_LMIX];
         right_mixer_amp_pwr <= pwr[`OSCB_PWR_RMIX];
         chip_cm_low <= cm[`OSCB_CM_CHIP];
         headphone_cm_sel <= cm[`OSCB_CM_HP_HI:`OSCB_CM_HP_LO];
         line_cm_regulator_input_supply <= cm[`OSCB_CM_LINE];
         headphone_regulator_input_supply <= cm[`OSCB_CM_HPSUP];
         regulator_input_supply_high_range <= next_range;
         left_headphone_current_limit <= next_limit[1];
         right_headphone_current_limit <= next_limit[0];
         left_headphone_driver_route <= route[3:0];
      end
   end

   // ---- checks ----
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_pwr_write;
      wr_pwr;
   endsequence

   property p_line_pwr;
      s_pwr_write |=> ##1 left_line_driver_pwr == $past(w_byte[`OSCB_PWR_LLINE], 2);
   endproperty
   a_line_pwr: assert property (p_line_pwr) else $error("line power not applied");

   property p_mix_pwr;
      s_pwr_write |=> ##1 right_mixer_amp_pwr == $past(w_byte[`OSCB_PWR_RMIX], 2);
   endproperty
   a_mix_pwr: assert property (p_mix_pwr) else $error("mixer power not applied");

   property p_reserved;
      pwr[7:6] == 2'b00 && cm[7] == 1'b0 && cm[2] == 1'b0 && rdata[31:8] == 24'h00_0000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_hp_cm;
      wr_cm |=> ##1 headphone_cm_sel == $past(w_byte[5:4], 2);
   endproperty
   a_hp_cm: assert property (p_hp_cm) else $error("headphone common mode wrong");

   property p_range;
      regulator_input_supply_high_range |-> headphone_regulator_input_supply;
   endproperty
   a_range: assert property (p_range) else $error("range without supply select");

   property p_ocp_reset;
      $rose(aresetn) |-> ocp[`OSCB_OCP_EN];
   endproperty
   a_ocp_reset: assert property (p_ocp_reset) else $error("detect not enabled at reset");

   sequence s_trip_rise;
      $rose(trip[1]);
   endsequence

   property p_trip_down;
      s_trip_rise |-> $past(ocp[`OSCB_OCP_ACT]) ##1 !left_headphone_driver_pwr;
   endproperty
   a_trip_down: assert property (p_trip_down) else $error("tripped driver left on");

   property p_limit;
      left_headphone_current_limit |-> !$past(ocp[`OSCB_OCP_ACT]) && !trip[1];
   endproperty
   a_limit: assert property (p_limit) else $error("limit with shutdown action");

   property p_bresp;
      do_write |=> bvalid && bresp == $past(wr_ok ? `OSCB_RESP_OKAY : `OSCB_RESP_SLVERR);
   endproperty
   a_bresp: assert property (p_bresp) else $error("write response missing");
endmodule // oscb_output_stage_bank

// File: oscb_host_model.sv
`include "oscb_regs.svh"
module oscb_host_model (
   // clock
   input wire logic aclk,
   // write channels
   output logic awvalid,
   input wire logic awready,
   output logic [11:0] awaddr,
   output logic [2:0] awprot,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   input wire logic bvalid,
   output logic bready,
   input wire logic [1:0] bresp,
   // read channels
   output logic arvalid,
   input wire logic arready,
   output logic [11:0] araddr,
   output logic [2:0] arprot,
   input wire logic rvalid,
   output logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, awprot, arprot, wstrb} = 34'h0;
      wdata = 32'h0;
   end

   // address and data are offered together; each drops once its own channel takes it
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
      logic a;
      logic w;
      a = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= {2'b00, idx, 2'b00};
      wvalid <= 1'b1;
      wdata <= {24'h000000, d};
      wstrb <= 4'hF;
      bready <= 1'b1;
      while (!(a && w)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            a = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] resp);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= {2'b00, idx, 2'b00};
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata[7:0];
      resp = rresp;
      rready <= 1'b0;
   endtask

   // the bank stays invisible until its page is chosen
   task automatic sel_page(input logic [7:0] p);
      logic [1:0] r;
      wr(`OSCB_IDX_PAGE, p, r);
   endtask
endmodule // oscb_host_model

// File: oscb_output_stage_bank_bench.sv
`include "oscb_regs.svh"
module oscb_output_stage_bank_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] BASE = 32'h4;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready, left_headphone_overcurrent, right_headphone_overcurrent, range_hi, hit;
   logic [11:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, route;
   logic [1:0] bresp, rresp, lim, resp;
   logic [5:0] pw;
   logic [4:0] cm;
   logic [7:0] d;
   int err_total, n_tests, seed, cnt, lv;
   int mdl [0:63];

   oscb_output_stage_bank #(.OCP_BASE_CYCLES(BASE)) uut (.aclk, .aresetn, .awvalid, .awready,
      .awaddr, .awprot, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
      .arready, .araddr, .arprot, .rvalid, .rready, .rdata, .rresp,
      .left_headphone_overcurrent, .right_headphone_overcurrent,
      .left_headphone_driver_pwr(pw[5]), .right_headphone_driver_pwr(pw[4]),
      .left_line_driver_pwr(pw[3]), .right_line_driver_pwr(pw[2]),
      .left_mixer_amp_pwr(pw[1]), .right_mixer_amp_pwr(pw[0]),
      .chip_cm_low(cm[4]), .headphone_cm_sel(cm[3:2]), .line_cm_regulator_input_supply(cm[1]),
      .headphone_regulator_input_supply(cm[0]), .regulator_input_supply_high_range(range_hi),
      .left_headphone_current_limit(lim[1]), .right_headphone_current_limit(lim[0]),
      .left_headphone_driver_route(route));

   oscb_host_model host (.aclk, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
      .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
      .rvalid, .rready, .rdata, .rresp);

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // catches a limit pulse that a sparse sample would miss
   always @(posedge aclk) if (lim[1] === 1'b1) hit <= 1'b1;

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task final_report();
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task settle(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask

   task outs();
      logic [7:0] c;
      c = 8'(mdl[`OSCB_IDX_CM]);
      settle(2);
      chk("pwr", pw, mdl[`OSCB_IDX_PWR]);
      chk("cm", cm, {c[6], c[5:4], c[3], c[1]});
      chk("range", range_hi, c[0] & c[1]);
      chk("route", route, mdl[`OSCB_IDX_ROUTE]);
   endtask

   task put(input logic [7:0] idx, input logic [7:0] v);
      logic [7:0] m;
      m = (idx == `OSCB_IDX_PWR) ? `OSCB_MASK_PWR : (idx == `OSCB_IDX_CM) ? `OSCB_MASK_CM :
         (idx == `OSCB_IDX_OCP) ? `OSCB_MASK_OCP : `OSCB_MASK_ROUTE;
      mdl[idx] = v & m;
      host.wr(idx, v & m, resp);
      chk("bresp", resp, `OSCB_RESP_OKAY);
      host.rd(idx, d, resp);
      chk("rdata", d, mdl[idx]);
   endtask

   initial begin
      seed = 32'h79697413;
      err_total = 0;
      n_tests = 0;
      hit = 1'b0;
      aresetn = 1'b0;
      left_headphone_overcurrent = 1'b0;
      right_headphone_overcurrent = 1'b0;
      for (int i = 0; i < 64; i++) mdl[i] = 0;
      mdl[`OSCB_IDX_OCP] = 8'h10;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      host.rd(`OSCB_IDX_PWR, d, resp);
      chk("page0", resp, `OSCB_RESP_SLVERR);
      host.sel_page(`OSCB_PAGE_OWN);
      for (int i = 9; i < 13; i++) begin
         host.rd(8'(i), d, resp);
         chk("reset", d, mdl[i]);
      end
      outs();
      for (int i = 0; i < 40; i++) begin
         d = 8'($random(seed));
         put(8'(9 + i % 4), d);
         outs();
      end
      host.wr(8'h20, 8'hFF, resp);
      chk("unmapped", resp, `OSCB_RESP_SLVERR);
      host.rd(8'h20, d, resp);
      chk("unmapped_rd", d, 8'h00);
      for (int k = 0; k < 8; k++) begin
         lv = (k == 0) ? 0 : int'(BASE) << (k - 1);
         put(`OSCB_IDX_OCP, 8'h10 | 8'(k << 1));
         @(posedge aclk);
         left_headphone_overcurrent <= 1'b1;
         cnt = 0;
         do begin
            settle(1);
            cnt++;
         end while (lim[1] !== 1'b1 && cnt < 600);
         chk("db_min", cnt >= lv, 1'b1);
         chk("db_max", cnt <= lv + 4, 1'b1);
         chk("r_lim", lim[0], 1'b0);
         @(posedge aclk);
         left_headphone_overcurrent <= 1'b0;
         settle(3);
         chk("lim_off", lim[1], 1'b0);
      end
      put(`OSCB_IDX_OCP, 8'h12);
      hit = 1'b0;
      repeat (6) begin
         @(posedge aclk);
         left_headphone_overcurrent <= 1'b1;
         repeat (3) @(posedge aclk);
         left_headphone_overcurrent <= 1'b0;
      end
      settle(4);
      chk("restart", hit, 1'b0);
      put(`OSCB_IDX_OCP, 8'h02);
      @(posedge aclk);
      left_headphone_overcurrent <= 1'b1;
      settle(20);
      chk("disabled", hit, 1'b0);
      @(posedge aclk);
      left_headphone_overcurrent <= 1'b0;
      put(`OSCB_IDX_PWR, 8'h30);
      put(`OSCB_IDX_OCP, 8'h13);
      @(posedge aclk);
      right_headphone_overcurrent <= 1'b1;
      cnt = 0;
      do begin
         settle(1);
         cnt++;
      end while (pw[4] !== 1'b0 && cnt < 600);
      chk("trip_time", cnt <= BASE + 4, 1'b1);
      chk("trip_pwr", pw[5:4], 2'b10);
      chk("trip_lim", lim, 2'b00);
      @(posedge aclk);
      right_headphone_overcurrent <= 1'b0;
      settle(5);
      chk("latched", pw[4], 1'b0);
      host.wr(`OSCB_IDX_STAT, 8'h01, resp);
      settle(3);
      chk("cleared", pw[5:4], 2'b11);
      // left side trips on its own and clears only through its own status bit
      @(posedge aclk);
      left_headphone_overcurrent <= 1'b1;
      settle(12);
      chk("trip_l", pw[5:4], 2'b01);
      @(posedge aclk);
      left_headphone_overcurrent <= 1'b0;
      settle(5);
      host.wr(`OSCB_IDX_STAT, 8'h01, resp);
      settle(3);
      chk("latched_l", pw[5:4], 2'b01);
      host.wr(`OSCB_IDX_STAT, 8'h02, resp);
      settle(3);
      chk("clear_l", pw[5:4], 2'b11);
      final_report();
   end

   // the full sequence needs well under ten thousand cycles
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      final_report();
   end
endmodule // oscb_output_stage_bank_bench
